// ===== fpec_pkg.sv
// shared constants for the flash program/erase controller and its device
package fpec_pkg;
    // ********************
    // timing
    // ********************
    localparam int CLK_MHZ             = 125;
    localparam int SETUP_DELAY_US      = 10;
    localparam int PUMP_SETTLE_US      = 5;
    localparam int WORD_WRITE_US       = 30;
    localparam int PROGRAM_HOLD_US     = 5;
    localparam int WIPE_HOLD_US        = 100;
    localparam int WIPE_PULSE_US       = 8000;
    localparam int READ_RECOVERY_US    = 1;
    localparam int SETUP_DELAY_CYC     = SETUP_DELAY_US * CLK_MHZ;
    localparam int PUMP_SETTLE_CYC     = PUMP_SETTLE_US * CLK_MHZ;
    localparam int WORD_WRITE_CYC      = WORD_WRITE_US * CLK_MHZ;
    localparam int PROGRAM_HOLD_CYC    = PROGRAM_HOLD_US * CLK_MHZ;
    localparam int WIPE_HOLD_CYC       = WIPE_HOLD_US * CLK_MHZ;
    localparam int WIPE_PULSE_CYC      = WIPE_PULSE_US * CLK_MHZ;
    localparam int READ_RECOVERY_CYC   = READ_RECOVERY_US * CLK_MHZ;
    localparam int TMR_W               = 20;
    // ********************
    // device map
    // ********************
    localparam logic [7:0]  CTL_OFS    = 8'hF7;
    localparam logic [7:0]  GUARD_OFS  = 8'hF5;
    localparam logic [7:0]  CTL_RESET  = 8'h00;
    localparam int          BIT_HALT   = 4;
    localparam int          BIT_HV     = 3;
    localparam int          BIT_WIPE   = 1;
    localparam int          BIT_PROG   = 0;
    localparam int          BIT_GUARD  = 0;
    localparam int          ARR_WORDS  = 16384;
    localparam int          IDX_W      = 14;
    localparam int          ROW_LSB    = 6;
    localparam logic [1:0]  BOOT_TOP   = 2'b11;
    localparam logic [15:0] ERASED     = 16'hFFFF;
    localparam logic [15:0] VECTOR_ADR = 16'hFFFE;
    // ********************
    // controller registers
    // ********************
    localparam logic [7:0] C_CMD_OFS   = 8'h00;
    localparam logic [7:0] C_ADDR_OFS  = 8'h04;
    localparam logic [7:0] C_DATA_OFS  = 8'h08;
    localparam logic [7:0] C_STAT_OFS  = 8'h0C;
    localparam logic [7:0] C_RDAT_OFS  = 8'h10;
    localparam int         CMD_PROG    = 0;
    localparam int         CMD_WIPE    = 1;
    localparam int         CMD_READ    = 2;
    localparam int         CMD_GUARD   = 3;
    localparam logic [1:0] HTRANS_NSEQ = 2'b10;
endpackage

// ===== fpec_if.sv
// internal memory bus between cpu-side controller and flash device
`timescale 1ns/1ps
interface fpec_if;
    logic        req;
    logic        wr;
    logic        reg_sel;
    logic        size8;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        ack;
    logic [15:0] rdata;
    modport dev (input req, wr, reg_sel, size8, addr, wdata, output ack, rdata);
    modport ctl (output req, wr, reg_sel, size8, addr, wdata, input ack, rdata);
endinterface

// ===== fpec_flash_dev.sv
// flash array with program/erase control register and interlocks
// Function
// - 8-bit control register, four live bits, reset zero
// - wait_clock_halt stops flash clock in wait
// - high voltage only after select and ordering
// - high_voltage_on drives charge pump and array
// - wipe and program select never both set
// - aligned reads one cycle, misaligned two
// - plain array writes ignored, reads answered
// - erased reads one, program clears, erase sets
// - program one aligned word per write
// - row is 64 aligned bytes
// - first write under program_select picks row
// - controller programs with setup, settle, word waits
// - steps in order, word interval under 40us
// - guarded boot block ignores program writes
// - any array write triggers erase, guard spares boot
// - stop or wait aborts program and erase
// - sequences run from code outside flash
// - erase fully before programming final data
// - array supplies reset vector after reset
// - boot_block_guard resets to one, zero enables
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module fpec_flash_dev
    import fpec_pkg::*;
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // memory bus
    fpec_if.dev       bus,
    // part power modes
    input  wire logic wait_mode,
    input  wire logic stop_mode,
    // analog side
    output logic      pump_on,
    output logic      flash_clk_en
);
    // ********************
    // storage and state
    // ********************
    logic [15:0]         mem [0:ARR_WORDS-1];
    logic                halt_ff;
    logic                hv_ff;
    logic                wipe_ff;
    logic                prog_ff;
    logic                guard_ff;
    logic                row_ok_ff;
    logic [IDX_W-6:0]    row_ff;
    logic                trig_ff;
    logic [IDX_W-1:0]    ptr_ff;
    logic                wiped_ff;
    logic                ack_ff;
    logic                mis_ff;
    logic [7:0]          hold_ff;
    logic [15:0]         rdata_ff;
    logic                clk_en_ff;

    function automatic logic boot_hit(input logic [IDX_W-1:0] idx);
        return idx[IDX_W-1 -: 2] == BOOT_TOP;
    endfunction

    // erased state of a never-programmed array
    initial begin
        for (int i = 0; i < ARR_WORDS; i++) begin
            mem[i] = ERASED;
        end
    end

    // ********************
    // access decode
    // ********************
    logic             take;
    logic             abort;
    logic             wr_ctl;
    logic             wr_guard;
    logic             arr_wr;
    logic             rd_mis;
    logic             hv_allowed;
    logic             prog_word;
    logic             erasing;
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] idx_nxt;
    logic [7:0]       ctl_val;

    assign take       = bus.req & ~ack_ff;
    assign abort      = stop_mode | wait_mode;
    assign idx        = bus.addr[IDX_W:1];
    assign idx_nxt    = idx + 1'b1;
    assign wr_ctl     = take & bus.wr & bus.reg_sel & (bus.addr[7:0] == CTL_OFS);
    assign wr_guard   = take & bus.wr & bus.reg_sel & (bus.addr[7:0] == GUARD_OFS);
    assign arr_wr     = take & bus.wr & ~bus.reg_sel;
    assign rd_mis     = take & ~bus.wr & ~bus.reg_sel & ~bus.size8 & bus.addr[0];
    assign hv_allowed = (prog_ff & row_ok_ff) | (wipe_ff & trig_ff);
    assign ctl_val    = {3'b000, halt_ff, hv_ff, 1'b0, wipe_ff, prog_ff};
    // word write inside the latched row, aligned, outside a guarded boot block
    assign prog_word  = arr_wr & prog_ff & hv_ff & row_ok_ff & ~abort
                      & ~bus.size8 & ~bus.addr[0]
                      & (bus.addr[IDX_W:ROW_LSB] == row_ff)
                      & ~(guard_ff & boot_hit(idx));
    assign erasing    = wipe_ff & hv_ff & trig_ff & ~abort & clk_en_ff & ~wiped_ff;

    // ********************
    // control register
    // ********************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halt_ff <= CTL_RESET[BIT_HALT];
            wipe_ff <= CTL_RESET[BIT_WIPE];
            prog_ff <= CTL_RESET[BIT_PROG];
        end else if (wr_ctl) begin
            halt_ff <= bus.wdata[BIT_HALT];
            if (!(bus.wdata[BIT_WIPE] & bus.wdata[BIT_PROG])) begin
                wipe_ff <= bus.wdata[BIT_WIPE];
                prog_ff <= bus.wdata[BIT_PROG];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hv_ff <= CTL_RESET[BIT_HV];
        end else if (abort) begin
            hv_ff <= 1'b0;
        end else if (wr_ctl) begin
            hv_ff <= bus.wdata[BIT_HV] & (hv_ff | hv_allowed);
        end
    end

    assign pump_on = hv_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            guard_ff <= 1'b1;
        end else if (wr_guard && !hv_ff) begin
            guard_ff <= bus.wdata[BIT_GUARD];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_en_ff <= 1'b1;
        end else begin
            clk_en_ff <= ~(wait_mode & halt_ff);
        end
    end

    assign flash_clk_en = clk_en_ff;

    // ********************
    // sequence latches
    // ********************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            row_ok_ff <= 1'b0;
            row_ff    <= '0;
        end else if (!prog_ff || abort) begin
            row_ok_ff <= 1'b0;
        end else if (arr_wr && !hv_ff && !row_ok_ff) begin
            row_ok_ff <= 1'b1;
            row_ff    <= bus.addr[IDX_W:ROW_LSB];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_ff <= 1'b0;
        end else if (!wipe_ff || abort) begin
            trig_ff <= 1'b0;
        end else if (arr_wr && !hv_ff) begin
            trig_ff <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_ff   <= '0;
            wiped_ff <= 1'b0;
        end else if (!trig_ff) begin
            ptr_ff   <= '0;
            wiped_ff <= 1'b0;
        end else if (erasing) begin
            ptr_ff   <= ptr_ff + 1'b1;
            wiped_ff <= &ptr_ff;
        end
    end

    // ********************
    // array update
    // ********************
    // plain always so the erased fill may share the array
    always @(posedge hclk) begin
        if (erasing) begin
            if (!(guard_ff && boot_hit(ptr_ff))) begin
                mem[ptr_ff] <= ERASED;
            end
        end else if (prog_word) begin
            mem[idx] <= mem[idx] & bus.wdata;
        end
    end

    // ********************
    // bus answer
    // ********************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_ff <= 1'b0;
            mis_ff <= 1'b0;
        end else if (rd_mis && !mis_ff) begin
            mis_ff <= 1'b1;
        end else begin
            ack_ff <= take;
            mis_ff <= 1'b0;
        end
    end

    // reads see the vector word at the top as soon as reset lifts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= '0;
            hold_ff  <= '0;
        end else if (take && !bus.wr) begin
            if (bus.reg_sel) begin
                unique case (bus.addr[7:0])
                    CTL_OFS:   rdata_ff <= {8'h00, ctl_val};
                    GUARD_OFS: rdata_ff <= {15'h0000, guard_ff};
                    default:   rdata_ff <= '0;
                endcase
            end else if (bus.size8) begin
                rdata_ff <= {8'h00, bus.addr[0] ? mem[idx][7:0] : mem[idx][15:8]};
            end else if (!bus.addr[0]) begin
                rdata_ff <= mem[idx];
            end else if (!mis_ff) begin
                hold_ff <= mem[idx][7:0];
            end else begin
                rdata_ff <= {hold_ff, mem[idx_nxt][15:8]};
            end
        end
    end

    assign bus.ack   = ack_ff;
    assign bus.rdata = rdata_ff;
endmodule

// ===== fpec_flash_ctl.sv
// ahb-lite controlled sequencer that programs, erases and reads the flash
`timescale 1ns/1ps
module fpec_flash_ctl
    import fpec_pkg::*;
#(
    parameter int HOLD_WIPE_CYC  = WIPE_HOLD_CYC,
    parameter int PULSE_WIPE_CYC = WIPE_PULSE_CYC
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // memory bus
    fpec_if.ctl              bus
);
    typedef enum logic [3:0] {
        S_IDLE, S_SEL, S_TRIG, S_NVS, S_HV, S_PGS, S_WORD, S_PULSE,
        S_DESEL, S_HOLD, S_HVOFF, S_RCV, S_READ, S_GUARD
    } fpec_state_type;

    fpec_state_type   state_ff;
    logic             wipe_ff;
    logic [TMR_W-1:0] tmr_ff;
    logic [15:0]      addr_ff;
    logic [15:0]      data_ff;
    logic [15:0]      rd_ff;
    logic             req_ff;
    logic             ph_wr_ff;
    logic [7:0]       ph_adr_ff;
    logic             go;
    logic [3:0]       cmd;

    function automatic logic [TMR_W-1:0] cyc(input int n);
        return TMR_W'(n - 1);
    endfunction

    // ********************
    // ahb slave
    // ********************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_ff  <= 1'b0;
            ph_adr_ff <= '0;
        end else if (hready) begin
            ph_wr_ff  <= hsel & (htrans == HTRANS_NSEQ) & hwrite;
            ph_adr_ff <= haddr[7:0];
        end
    end

    assign cmd = hwdata[3:0];
    assign go  = ph_wr_ff & (ph_adr_ff == C_CMD_OFS) & (state_ff == S_IDLE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff <= '0;
            data_ff <= '0;
        end else if (ph_wr_ff && ph_adr_ff == C_ADDR_OFS) begin
            addr_ff <= hwdata[15:0];
        end else if (ph_wr_ff && ph_adr_ff == C_DATA_OFS) begin
            data_ff <= hwdata[15:0];
        end
    end

    always_comb begin
        unique case (ph_adr_ff)
            C_ADDR_OFS: hrdata = {16'h0000, addr_ff};
            C_DATA_OFS: hrdata = {16'h0000, data_ff};
            C_STAT_OFS: hrdata = {31'h00000000, state_ff != S_IDLE};
            C_RDAT_OFS: hrdata = {16'h0000, rd_ff};
            default:    hrdata = '0;
        endcase
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ********************
    // sequencer
    // ********************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= S_IDLE;
            wipe_ff  <= 1'b0;
            tmr_ff   <= '0;
            req_ff   <= 1'b0;
            rd_ff    <= '0;
        end else if (req_ff) begin
            if (bus.ack) begin
                req_ff <= 1'b0;
                unique case (state_ff)
                    S_SEL:   state_ff <= S_TRIG;
                    S_TRIG: begin
                        state_ff <= S_NVS;
                        tmr_ff   <= cyc(SETUP_DELAY_CYC);
                    end
                    S_HV: begin
                        state_ff <= wipe_ff ? S_PULSE : S_PGS;
                        tmr_ff   <= wipe_ff ? cyc(PULSE_WIPE_CYC) : cyc(PUMP_SETTLE_CYC);
                    end
                    S_WORD: begin
                        state_ff <= S_PULSE;
                        tmr_ff   <= cyc(WORD_WRITE_CYC);
                    end
                    S_DESEL: begin
                        state_ff <= S_HOLD;
                        tmr_ff   <= wipe_ff ? cyc(HOLD_WIPE_CYC) : cyc(PROGRAM_HOLD_CYC);
                    end
                    S_HVOFF: begin
                        state_ff <= S_RCV;
                        tmr_ff   <= cyc(READ_RECOVERY_CYC);
                    end
                    S_READ: begin
                        state_ff <= S_IDLE;
                        rd_ff    <= bus.rdata;
                    end
                    default: state_ff <= S_IDLE;
                endcase
            end
        end else if (state_ff == S_IDLE) begin
            if (go && cmd[CMD_PROG]) begin
                state_ff <= S_SEL;
                wipe_ff  <= 1'b0;
                req_ff   <= 1'b1;
            end else if (go && cmd[CMD_WIPE]) begin
                state_ff <= S_SEL;
                wipe_ff  <= 1'b1;
                req_ff   <= 1'b1;
            end else if (go && cmd[CMD_READ]) begin
                state_ff <= S_READ;
                req_ff   <= 1'b1;
            end else if (go && cmd[CMD_GUARD]) begin
                state_ff <= S_GUARD;
                req_ff   <= 1'b1;
            end
        end else if (tmr_ff != '0) begin
            tmr_ff <= tmr_ff - 1'b1;
        end else begin
            req_ff <= 1'b1;
            unique case (state_ff)
                S_TRIG:  state_ff <= S_TRIG;
                S_NVS:   state_ff <= S_HV;
                S_PGS:   state_ff <= S_WORD;
                S_PULSE: state_ff <= S_DESEL;
                S_HOLD:  state_ff <= S_HVOFF;
                default: begin
                    state_ff <= S_IDLE;
                    req_ff   <= 1'b0;
                end
            endcase
        end
    end

    // ********************
    // bus drive
    // ********************
    logic [7:0] sel_bits;
    assign sel_bits = wipe_ff ? 8'(1 << BIT_WIPE) : 8'(1 << BIT_PROG);

    always_comb begin
        bus.req     = req_ff;
        bus.wr      = state_ff != S_READ;
        bus.reg_sel = 1'b1;
        bus.size8   = 1'b0;
        bus.addr    = {8'h00, CTL_OFS};
        bus.wdata   = '0;
        unique case (state_ff)
            S_SEL:   bus.wdata = {8'h00, sel_bits};
            S_HV:    bus.wdata = {8'h00, sel_bits | 8'(1 << BIT_HV)};
            S_DESEL: bus.wdata = 16'(1 << BIT_HV);
            S_TRIG, S_WORD, S_READ: begin
                bus.reg_sel = 1'b0;
                bus.addr    = addr_ff;
                bus.wdata   = data_ff;
            end
            S_GUARD: begin
                bus.addr  = {8'h00, GUARD_OFS};
                bus.wdata = data_ff;
            end
            default: bus.wdata = '0;
        endcase
    end
endmodule

// ===== fpec_bus_sva.sv
// assertions on the memory bus between controller and flash device
`timescale 1ns/1ps
module fpec_bus_sva
    import fpec_pkg::*;
(
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // memory bus
    input wire logic        req,
    input wire logic        wr,
    input wire logic        reg_sel,
    input wire logic        size8,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic        ack,
    input wire logic [15:0] rdata,
    // power modes and analog side
    input wire logic        wait_mode,
    input wire logic        stop_mode,
    input wire logic        pump_on,
    input wire logic        flash_clk_en
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ****
    // helpers
    // ****
    wire logic ctl_write;
    assign ctl_write = req && !ack && wr && reg_sel && (addr[7:0] == CTL_OFS);
    wire logic hv_write;
    assign hv_write = ctl_write && wdata[BIT_HV];
    // ****
    // checks
    // ****
    a_ack_one_pulse: assert property (ack |=> !ack) else $error("ack too long");
    a_ack_has_req: assert property (ack |-> $past(req)) else $error("stray ack");
    a_aligned_one_cycle: assert property (
        $rose(req) && (wr || reg_sel || size8 || !addr[0]) |=> ack) else $error("slow access");
    a_req_released: assert property (ack |=> !req) else $error("req held after ack");
    a_abort_drops_pump: assert property (
        (stop_mode || wait_mode) |=> !pump_on) else $error("pump kept in stop or wait");
    a_clock_runs: assert property (!wait_mode |=> flash_clk_en) else $error("clock halted");
    a_pump_rise_cause: assert property (
        $rose(pump_on) |-> $past(hv_write)) else $error("pump rose alone");
    a_pump_off_write: assert property (
        ctl_write && !wdata[BIT_HV] |=> !pump_on) else $error("pump not dropped");
    a_rdata_held: assert property (
        (!req || wr) |=> $stable(rdata)) else $error("read data moved");
endmodule

// ===== tb_flash_program_erase_ctrl.sv
// self-checking bench for the flash controller and flash device
`timescale 1ns/1ps
module tb_flash_program_erase_ctrl
    import fpec_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        wait_a, stop_a, pump_a, clk_en_a, wait_b, pump_b, clk_en_b;
    logic [31:0] q;
    logic [15:0] r, d1, d2, d3, ad, ba, ca;
    logic [15:0] wa [4] = '{16'h0140, 16'h0105, 16'h0104, 16'h0102};
    int          fails, checks_done, lat, cnt;
    fpec_if ia ();
    fpec_if ib ();
    fpec_flash_ctl #(
        .HOLD_WIPE_CYC  (32'h14),
        .PULSE_WIPE_CYC (32'h4E20)
    ) u_fpec_flash_ctl (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (),
        .bus       (ia)
    );
    fpec_flash_dev u_fpec_flash_dev (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .bus          (ia),
        .wait_mode    (wait_a),
        .stop_mode    (stop_a),
        .pump_on      (pump_a),
        .flash_clk_en (clk_en_a)
    );
    fpec_flash_dev u_fpec_flash_dev_b (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .bus          (ib),
        .wait_mode    (wait_b),
        .stop_mode    (1'b0),
        .pump_on      (pump_b),
        .flash_clk_en (clk_en_b)
    );
    fpec_bus_sva u_fpec_bus_sva (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .req          (ia.req),
        .wr           (ia.wr),
        .reg_sel      (ia.reg_sel),
        .size8        (ia.size8),
        .addr         (ia.addr),
        .wdata        (ia.wdata),
        .ack          (ia.ack),
        .rdata        (ia.rdata),
        .wait_mode    (wait_a),
        .stop_mode    (stop_a),
        .pump_on      (pump_a),
        .flash_clk_en (clk_en_a)
    );
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // ****
    // helpers
    // ****
    function automatic logic [15:0] after_prog(input logic [15:0] old, input logic [15:0] nw);
        return old & nw;
    endfunction
    task automatic summarize();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic hang(input int n, input int lim);
        if (n >= lim) begin
            fails++;
            summarize();
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NSEQ;
        hwrite <= w;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 99);
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 99);
        q = hrdata;
        hang(n, 99);
    endtask
    task automatic run(input int op, input logic [15:0] a, input logic [15:0] d, input bit go);
        int n;
        n = 0;
        ahb(1'b1, C_ADDR_OFS, {16'h0, a});
        ahb(1'b1, C_DATA_OFS, {16'h0, d});
        ahb(1'b1, C_CMD_OFS, 32'h1 << op);
        while (go && n < 20000 && (n == 0 || q[0] !== 1'b0)) begin
            ahb(1'b0, C_STAT_OFS, 32'h0);
            n++;
        end
        hang(n, 20000);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        run(CMD_READ, a, 16'h0, 1'b1);
        ahb(1'b0, C_RDAT_OFS, 32'h0);
        check("array word", q, {16'h0, e});
    endtask
    task automatic dreq(input logic w, rs, s8, input logic [15:0] a, input logic [15:0] d);
        lat = 0;
        ib.req     <= 1'b1;
        ib.wr      <= w;
        ib.reg_sel <= rs;
        ib.size8   <= s8;
        ib.addr    <= a;
        ib.wdata   <= d;
        do begin
            @(posedge hclk);
            lat++;
        end while (ib.ack !== 1'b1 && lat < 9);
        r = ib.rdata;
        ib.req <= 1'b0;
        @(posedge hclk);
        hang(lat, 9);
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        {fails, checks_done, hresetn, hwrite, wait_a, stop_a, wait_b} = '0;
        {haddr, hwdata, htrans, ib.req, ib.wr, ib.reg_sel, ib.size8, ib.addr, ib.wdata} = '0;
        hsel = 1'b1;
        hsize = 3'b010;
        void'($urandom(32'hF1DB));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b1, 8'h14, 32'hFFFF);
        ahb(1'b0, 8'h14, 32'h0);
        check("unmapped", q, 32'h0);
        rd(VECTOR_ADR, ERASED);
        ad = 16'($urandom_range(32'h5FFE)) & 16'hFFFE;
        ba = 16'h6000 + (16'($urandom_range(32'h1FFE)) & 16'hFFFE);
        d1 = 16'($urandom());
        d2 = 16'($urandom());
        run(CMD_PROG, ad, d1, 1'b1);
        rd(ad, after_prog(ERASED, d1));
        run(CMD_PROG, ad, d2, 1'b1);
        rd(ad, after_prog(d1, d2));
        run(CMD_PROG, ba, d1, 1'b1);
        rd(ba, ERASED);
        run(CMD_GUARD, 16'h0, 16'h0, 1'b1);
        run(CMD_PROG, ba, d2, 1'b1);
        rd(ba, after_prog(ERASED, d2));
        run(CMD_GUARD, 16'h0, 16'h1, 1'b1);
        run(CMD_WIPE, ad, 16'h0, 1'b1);
        rd(ad, ERASED);
        rd(ba, after_prog(ERASED, d2));
        run(CMD_PROG, ad, d1, 1'b1);
        rd(ad, d1);
        for (int i = 0; i < 2; i++) begin
            ca = 16'($urandom_range(32'h5FFE)) & 16'hFFFE;
            run(CMD_PROG, ca, d1, 1'b0);
            cnt = 0;
            while (pump_a !== 1'b1 && cnt < 3000) begin
                @(posedge hclk);
                cnt++;
            end
            hang(cnt, 3000);
            check("pump up", pump_a, 32'h1);
            {wait_a, stop_a} <= (i == 0) ? 2'b01 : 2'b10;
            repeat (2) @(posedge hclk);
            check("pump abort", pump_a, 32'h0);
            check("clock runs", clk_en_a, 32'h1);
            {wait_a, stop_a} <= 2'b00;
            run(CMD_READ, ca, 16'h0, 1'b1);
            rd(ca, ERASED);
        end
        dreq(1'b0, 1'b1, 1'b1, {8'h0, CTL_OFS}, 16'h0);
        check("ctl reset", r[7:0], CTL_RESET);
        dreq(1'b0, 1'b1, 1'b1, {8'h0, GUARD_OFS}, 16'h0);
        check("guard reset", r[0], 32'h1);
        dreq(1'b1, 1'b0, 1'b0, 16'h0100, 16'h0);
        dreq(1'b0, 1'b0, 1'b0, 16'h0100, 16'h0);
        check("plain write", r, ERASED);
        check("aligned wait", lat, 2);
        dreq(1'b1, 1'b1, 1'b1, {8'h0, CTL_OFS}, 16'h001B);
        dreq(1'b0, 1'b1, 1'b1, {8'h0, CTL_OFS}, 16'h0);
        check("both selects", r[7:0], 8'h10);
        dreq(1'b1, 1'b1, 1'b1, {8'h0, CTL_OFS}, 16'h0001);
        dreq(1'b1, 1'b1, 1'b1, {8'h0, CTL_OFS}, 16'h00FF);
        dreq(1'b0, 1'b1, 1'b1, {8'h0, CTL_OFS}, 16'h0);
        check("ctl bits", r[7:0], 8'h11);
        d3 = 16'($urandom());
        dreq(1'b1, 1'b0, 1'b0, 16'h0100, 16'h0);
        dreq(1'b1, 1'b1, 1'b1, {8'h0, CTL_OFS}, 16'h0019);
        check("pump on", pump_b, 32'h1);
        for (int i = 0; i < 4; i++) begin
            dreq(1'b1, 1'b0, i == 2, wa[i], d3);
        end
        dreq(1'b1, 1'b1, 1'b1, {8'h0, CTL_OFS}, 16'h0018);
        dreq(1'b1, 1'b1, 1'b1, {8'h0, CTL_OFS}, 16'h0010);
        check("pump off", pump_b, 32'h0);
        dreq(1'b0, 1'b0, 1'b0, 16'h0102, 16'h0);
        check("row word", r, after_prog(ERASED, d3));
        dreq(1'b0, 1'b0, 1'b0, 16'h0140, 16'h0);
        check("other row", r, ERASED);
        dreq(1'b0, 1'b0, 1'b0, 16'h0104, 16'h0);
        check("odd and byte", r, ERASED);
        dreq(1'b0, 1'b0, 1'b0, 16'h0100, 16'h0);
        check("row pick", r, ERASED);
        dreq(1'b0, 1'b0, 1'b0, 16'h0101, 16'h0);
        check("misaligned", r, {8'hFF, d3[15:8]});
        check("misaligned wait", lat, 3);
        dreq(1'b0, 1'b0, 1'b1, 16'h0103, 16'h0);
        check("byte wait", lat, 2);
        check("odd byte", r, {8'h00, d3[7:0]});
        wait_b <= 1'b1;
        repeat (3) @(posedge hclk);
        check("halted clock", clk_en_b, 32'h0);
        wait_b <= 1'b0;
        summarize();
    end
endmodule
